// file: logic/ems_pkg.sv
// Purpose: Shared constants and types for the measurement sequencer.
// Assumes: 100 MHz clock, 32-bit AHB-Lite register access.
// Notes:   Register offsets are byte addresses.
package ems_pkg;

  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] REG_CTRL_HUM  = 8'h00;
  localparam logic [7:0] REG_CTRL_MEAS = 8'h04;
  localparam logic [7:0] REG_CONFIG    = 8'h08;
  localparam logic [7:0] REG_STATUS    = 8'h0c;
  localparam logic [7:0] REG_PRES      = 8'h10;
  localparam logic [7:0] REG_TEMP      = 8'h14;
  localparam logic [7:0] REG_HUM       = 8'h18;
  localparam logic [7:0] REG_CONV_P    = 8'h1c;
  localparam logic [7:0] REG_CONV_T    = 8'h20;
  localparam logic [7:0] REG_CONV_H    = 8'h24;
  localparam logic [7:0] REG_RESET     = 8'h28;
  localparam logic [7:0] REG_ID        = 8'h2c;

  // ****************************************************************
  // Field positions and values
  // ****************************************************************
  localparam int          MODE_LSB     = 0;
  localparam int          OSP_LSB      = 2;
  localparam int          OST_LSB      = 5;
  localparam int          FILT_LSB     = 2;
  localparam int          SB_LSB       = 5;
  localparam logic [7:0]  RESET_KEY    = 8'hb6;
  localparam logic [19:0] SKIP_VALUE   = 20'h80000;
  localparam logic [15:0] HUM_SKIP     = 16'h8000;
  localparam logic [31:0] CHIP_ID      = 32'h0000005a; // Arbitrary value.

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_MHZ        = 100;
  localparam int SB_MIN_US_X10  = 5;        // 0.5 ms standby.
  localparam int SB_MAX_MS      = 1000;     // 1000 ms standby.
  localparam int SB_MIN_CYC     = SB_MIN_US_X10 * 100 * CLK_MHZ;
  localparam int SB_MAX_CYC     = SB_MAX_MS * 1000 * CLK_MHZ;
  localparam int CONV_CYC       = 16;       // Cycles per single conversion.

  typedef enum logic [1:0] {
    MODE_SLEEP,
    MODE_FORCED,
    MODE_NORMAL
  } ems_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_TEMP,
    ST_PRES,
    ST_HUM,
    ST_FILT,
    ST_STANDBY
  } ems_state_t;

  typedef struct packed {
    logic [1:0] mode;
    logic [2:0] osrs_p;
    logic [2:0] osrs_t;
    logic [2:0] osrs_h;
    logic [2:0] filt;
    logic [2:0] sb_sel;
  } ems_cfg_t;

endpackage : ems_pkg

// file: logic/ems_seq.sv
// Purpose: Sleep/forced/normal sequencer with IIR filter for T and P.
// Assumes: Converter samples supplied by software-written raw registers.
// Notes:   Registers reached over AHB-Lite, zero wait states.
//
// Register access over AHB-Lite and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none

module ems_seq
  import ems_pkg::*;
#(
  parameter int SB_MIN_CYCLES = SB_MIN_CYC,
  parameter int SB_MAX_CYCLES = SB_MAX_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_b_i,
  input  wire logic        core_supply_ok_i,
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic      [31:0] hrdata_o,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic             pins_oe_allow_o,
  output logic             measuring_o,
  output ems_cfg_t         cfg_o
);
  import ems_pkg::*;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic ems_mode_t decode_mode(input logic [1:0] f);
    case (f)
      2'h0:    decode_mode = MODE_SLEEP;
      2'h3:    decode_mode = MODE_NORMAL;
      default: decode_mode = MODE_FORCED;
    endcase
  endfunction : decode_mode

  // Coefficient exponent: 0 off, 1..4 for 2..16, larger codes clip to 16.
  function automatic logic [2:0] coef_shift(input logic [2:0] f);
    coef_shift = (f > 3'h4) ? 3'h4 : f;
  endfunction : coef_shift

  // One filter step for shift k; k of zero passes the sample.
  function automatic logic [19:0] iir(input logic [19:0] old,
                                     input logic [19:0] smp,
                                     input logic [2:0]  k);
    logic [24:0] acc;
    acc = 25'h0;
    if (k == 3'h0) begin
      iir = smp;
    end else begin
      acc = ({5'h0, old} << k) - {5'h0, old} + {5'h0, smp};
      iir = 20'(acc >> k);
    end
  endfunction : iir

  // Unfiltered resolution: keep 16+(code-1) top bits, zero the rest.
  function automatic logic [19:0] trunc(input logic [19:0] v,
                                        input logic [2:0]  os);
    logic [2:0] keep;
    keep = (os > 3'h5) ? 3'h4 : 3'(os - 3'h1);
    trunc = v & ~(20'hfffff >> (5'd16 + 5'(keep)));
  endfunction : trunc

  function automatic logic [31:0] sb_cycles(input logic [2:0] s);
    case (s)
      3'h0:    sb_cycles = 32'(SB_MIN_CYCLES);
      3'h1:    sb_cycles = 32'(SB_MIN_CYCLES * 125);
      3'h2:    sb_cycles = 32'(SB_MIN_CYCLES * 250);
      3'h3:    sb_cycles = 32'(SB_MIN_CYCLES * 500);
      3'h4:    sb_cycles = 32'(SB_MIN_CYCLES * 1000);
      3'h6:    sb_cycles = 32'(SB_MIN_CYCLES * 20);
      3'h7:    sb_cycles = 32'(SB_MIN_CYCLES * 40);
      default: sb_cycles = 32'(SB_MAX_CYCLES);
    endcase
  endfunction : sb_cycles

  // ****************************************************************
  // Bus slave
  // ****************************************************************
  logic        ap_wr;
  logic        ap_rd;
  logic [7:0]  ap_addr;
  logic        dp_wr;
  logic [7:0]  dp_addr;
  ems_cfg_t    cfg;
  logic        pend_valid;
  logic [1:0]  pend_mode;
  logic        soft_rst;
  logic        run_rst;
  ems_state_t  state;
  logic [19:0] raw_p;
  logic [19:0] raw_t;
  logic [15:0] raw_h;
  logic [19:0] mem_p;
  logic [19:0] mem_t;
  logic        init_t;
  logic        init_p;
  logic [19:0] out_p;
  logic [19:0] out_t;
  logic [15:0] out_h;
  logic [31:0] cnt;
  logic        busy;

  assign ap_wr = hsel_i & htrans_i[1] & hready_i & hwrite_i;
  assign ap_rd = hsel_i & htrans_i[1] & hready_i & ~hwrite_i;
  assign ap_addr = haddr_i[7:0];
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign busy = (state != ST_IDLE) && (state != ST_STANDBY);
  assign measuring_o = busy;
  assign cfg_o = cfg;
  assign pins_oe_allow_o = core_supply_ok_i;
  // Reset from pin or soft command; core supply loss acts as power-on reset.
  assign run_rst = ~rst_b_i | soft_rst | ~core_supply_ok_i;

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      dp_wr   <= 1'b0;
      dp_addr <= 8'h00;
    end else begin
      dp_wr   <= ap_wr;
      dp_addr <= ap_addr;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      hrdata_o <= 32'h0;
    end else if (ap_rd) begin
      case (ap_addr)
        REG_CTRL_HUM:  hrdata_o <= {29'h0, cfg.osrs_h};
        REG_CTRL_MEAS: hrdata_o <= {24'h0, cfg.osrs_t, cfg.osrs_p,
                                    cfg.mode};
        REG_CONFIG:    hrdata_o <= {24'h0, cfg.sb_sel, cfg.filt, 2'h0};
        REG_STATUS:    hrdata_o <= {29'h0, pend_valid, busy, init_t | init_p};
        REG_PRES:      hrdata_o <= {12'h0, out_p};
        REG_TEMP:      hrdata_o <= {12'h0, out_t};
        REG_HUM:       hrdata_o <= {16'h0, out_h};
        REG_CONV_P:    hrdata_o <= {12'h0, raw_p};
        REG_CONV_T:    hrdata_o <= {12'h0, raw_t};
        REG_CONV_H:    hrdata_o <= {16'h0, raw_h};
        REG_ID:        hrdata_o <= CHIP_ID;
        default:       hrdata_o <= 32'h0;
      endcase
    end
  end

  // ****************************************************************
  // Configuration and deferred mode change
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!rst_b_i) begin
      soft_rst <= 1'b0;
    end else begin
      soft_rst <= dp_wr && dp_addr == REG_RESET &&
                  hwdata_i[7:0] == RESET_KEY;
    end
  end

  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      cfg        <= '0;
      pend_valid <= 1'b0;
      pend_mode  <= 2'h0;
    end else begin
      if (dp_wr && dp_addr == REG_CTRL_HUM && !pend_valid) begin
        cfg.osrs_h <= hwdata_i[2:0];
      end
      if (dp_wr && dp_addr == REG_CONFIG) begin
        cfg.filt   <= hwdata_i[FILT_LSB +: 3];
        cfg.sb_sel <= hwdata_i[SB_LSB +: 3];
      end
      if (dp_wr && dp_addr == REG_CTRL_MEAS) begin
        cfg.osrs_p <= hwdata_i[OSP_LSB +: 3];
        cfg.osrs_t <= hwdata_i[OST_LSB +: 3];
        if (busy && !pend_valid) begin
          pend_valid <= 1'b1;
          pend_mode  <= hwdata_i[MODE_LSB +: 2];
        end else if (!busy && !pend_valid) begin
          cfg.mode <= hwdata_i[MODE_LSB +: 2];
        end
      end
      if (state == ST_FILT) begin
        if (pend_valid) begin
          cfg.mode   <= pend_mode;
          pend_valid <= 1'b0;
        end else if (decode_mode(cfg.mode) == MODE_FORCED) begin
          cfg.mode <= 2'h0;
        end
      end
      // A change pended on the closing update edge lands once idle.
      if (pend_valid && !busy) begin
        cfg.mode   <= pend_mode;
        pend_valid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Sequencer
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      state <= ST_IDLE;
      cnt   <= 32'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          cnt <= 32'h0;
          if (decode_mode(cfg.mode) != MODE_SLEEP) begin
            state <= ST_TEMP;
          end
        end
        ST_TEMP, ST_PRES, ST_HUM: begin
          if (cnt >= 32'(CONV_CYC - 1)) begin
            cnt   <= 32'h0;
            state <= (state == ST_TEMP) ? ST_PRES :
                     (state == ST_PRES) ? ST_HUM : ST_FILT;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        ST_FILT: begin
          cnt <= 32'h0;
          // The mode about to apply decides whether a standby follows.
          state <= (decode_mode(pend_valid ? pend_mode : cfg.mode)
                    == MODE_NORMAL) ? ST_STANDBY : ST_IDLE;
        end
        ST_STANDBY: begin
          if (decode_mode(cfg.mode) != MODE_NORMAL) begin
            state <= ST_IDLE;
          end else if (cnt >= sb_cycles(cfg.sb_sel) - 32'h1) begin
            cnt   <= 32'h0;
            state <= ST_TEMP;
          end else begin
            cnt <= cnt + 32'h1;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Raw converter samples; written by software to stand in for the ADC.
  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      raw_p <= 20'h0;
      raw_t <= 20'h0;
      raw_h <= 16'h0;
    end else if (dp_wr) begin
      if (dp_addr == REG_CONV_P) raw_p <= hwdata_i[19:0];
      if (dp_addr == REG_CONV_T) raw_t <= hwdata_i[19:0];
      if (dp_addr == REG_CONV_H) raw_h <= hwdata_i[15:0];
    end
  end

  // ****************************************************************
  // IIR filter and output registers
  // ****************************************************************
  logic [2:0] k;
  logic       skip_t;
  logic       skip_p;
  assign k = coef_shift(cfg.filt);
  assign skip_t = (cfg.osrs_t == 3'h0);
  assign skip_p = (cfg.osrs_p == 3'h0);

  always_ff @(posedge clk_i) begin
    if (run_rst) begin
      init_t    <= 1'b1;
      init_p    <= 1'b1;
      mem_p     <= 20'h0;
      mem_t     <= 20'h0;
      out_p     <= SKIP_VALUE;
      out_t     <= SKIP_VALUE;
      out_h     <= HUM_SKIP;
    end else begin
      if (state == ST_FILT) begin
        // A channel leaves init only on a sample it really took, so one
        // skipped across a filter write still restarts from a clean memory.
        if (skip_t) begin
          out_t <= SKIP_VALUE;
        end else if (k == 3'h0) begin
          out_t  <= trunc(raw_t, cfg.osrs_t);
          mem_t  <= raw_t;
          init_t <= 1'b0;
        end else begin
          mem_t  <= init_t ? raw_t : iir(mem_t, raw_t, k);
          out_t  <= init_t ? raw_t : iir(mem_t, raw_t, k);
          init_t <= 1'b0;
        end
        if (skip_p) begin
          out_p <= SKIP_VALUE;
        end else if (k == 3'h0) begin
          out_p  <= trunc(raw_p, cfg.osrs_p);
          mem_p  <= raw_p;
          init_p <= 1'b0;
        end else begin
          mem_p  <= init_p ? raw_p : iir(mem_p, raw_p, k);
          out_p  <= init_p ? raw_p : iir(mem_p, raw_p, k);
          init_p <= 1'b0;
        end
        out_h <= (cfg.osrs_h == 3'h0) ? HUM_SKIP : raw_h;
      end
      // A filter write landing on the update cycle still re-arms init.
      if (dp_wr && dp_addr == REG_CONFIG) begin
        init_t <= 1'b1;
        init_p <= 1'b1;
      end
    end
  end

endmodule : ems_seq

`default_nettype wire

// file: bench/ems_host.sv
// Purpose: AHB-Lite host model that configures and reads the sequencer.
// Assumes: Single word transfers, one slave, caller starts after an edge.
// Notes:   Released lines carry inverted data so stale values never match.
`timescale 1ns/1ps
`default_nettype none
module ems_host (
  input  wire logic        clk_i,
  input  wire logic        hready_i,
  input  wire logic [31:0] hrdata_i,
  output logic             hsel_o,
  output logic      [31:0] haddr_o,
  output logic      [1:0]  htrans_o,
  output logic             hwrite_o,
  output logic      [2:0]  hsize_o,
  output logic      [31:0] hwdata_o
);
  int hangs = 0;
  initial begin
    hsel_o   = 1'b0;
    haddr_o  = 32'h0;
    htrans_o = 2'h0;
    hwrite_o = 1'b0;
    hsize_o  = 3'h2;
    hwdata_o = 32'h0;
  end
  task automatic wait_rdy();
    int n;
    n = 0;
    @(posedge clk_i);
    while (hready_i !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20) hangs++;
  endtask : wait_rdy
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd);
    hsel_o   <= 1'b1;
    haddr_o  <= {24'h0, a};
    htrans_o <= 2'h2;
    hwrite_o <= wr;
    wait_rdy();
    hsel_o   <= 1'b0;
    htrans_o <= 2'h0;
    haddr_o  <= ~haddr_o;
    hwdata_o <= wr ? wd : ~hwdata_o;
    wait_rdy();
    rd = hrdata_i;
    hwdata_o <= ~hwdata_o;
  endtask : xfer
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] unused;
    xfer(1'b1, a, d, unused);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    xfer(1'b0, a, 32'h0, d);
  endtask : rd
endmodule : ems_host
`default_nettype wire

// file: bench/ems_seq_props.sv
// Purpose: Port-level checks of the measurement sequencer.
// Assumes: Standby code 0 lasts SB_MIN_CYCLES cycles.
// Notes:   Bound to every ems_seq instance.
`timescale 1ns/1ps
`default_nettype none
module ems_seq_props
  import ems_pkg::*;
#(
  parameter int SB_MIN_CYCLES = 4,
  parameter int SB_MAX_CYCLES = 40
) (
  input wire logic     clk_i,
  input wire logic     rst_b_i,
  input wire logic     core_supply_ok_i,
  input wire logic     hreadyout_o,
  input wire logic     hresp_o,
  input wire logic     pins_oe_allow_o,
  input wire logic     measuring_o,
  input wire ems_cfg_t cfg_o
);
  // ****************************************************************
  // Properties
  // ****************************************************************
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  // Helper counters: length of the running measurement, and idle cycles
  // since a normal period with the shortest standby ended.
  logic [7:0]  meas_len;
  logic [31:0] gap_len;
  logic        gap_on;
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || !measuring_o) begin
      meas_len <= 8'h0;
    end else begin
      meas_len <= meas_len + 8'h1;
    end
  end
  always_ff @(posedge clk_i) begin
    if (!rst_b_i || measuring_o || cfg_o.mode != 2'b11 ||
        cfg_o.sb_sel != 3'h0) begin
      gap_on  <= 1'b0;
      gap_len <= 32'h0;
    end else begin
      gap_on  <= gap_on || $fell(measuring_o);
      gap_len <= gap_len + 32'h1;
    end
  end
  hready_ok_a: assert property (hreadyout_o == 1'b1 && hresp_o == 1'b0)
    else $error("bus answer not ready or not okay");
  pins_follow_a: assert property (pins_oe_allow_o == core_supply_ok_i)
    else $error("pin enable does not follow core supply");
  reset_sleep_a: assert property ($rose(rst_b_i) |->
    cfg_o == '0 && !measuring_o) else $error("not asleep after reset");
  supply_clear_a: assert property (!core_supply_ok_i |=> cfg_o == '0)
    else $error("config kept without core supply");
  sleep_idle_a: assert property (!measuring_o && cfg_o.mode == 2'b00
    |=> !measuring_o || $changed(cfg_o.mode))
    else $error("measurement started in sleep");
  meas_bound_a: assert property ($rose(measuring_o)
    |-> ##[1:60] !measuring_o) else $error("measurement too long");
  // In normal mode with standby code 0, measuring restarts after SB_MIN_CYCLES idle cycles.
  normal_cycle_a: assert property (gap_on |->
    measuring_o == (gap_len == 32'(SB_MIN_CYCLES)))
    else $error("normal standby gap wrong");
  filt_short_a: assert property ($fell(measuring_o) && cfg_o != '0
    |-> meas_len == 8'(3 * CONV_CYC + 1))
    else $error("measurement period length wrong");
  fast_a: assert property ($fell(measuring_o) && cfg_o.mode == 2'b11
    |=> !$rose(measuring_o)) else $error("no gap between periods");
  forced_c: cover property ($fell(measuring_o) && cfg_o.mode == 2'b00);
  normal_c: cover property ($fell(measuring_o) && cfg_o.mode == 2'b11);
  supply_c: cover property (!core_supply_ok_i);
endmodule : ems_seq_props
bind ems_seq ems_seq_props #(
  .SB_MIN_CYCLES(SB_MIN_CYCLES),
  .SB_MAX_CYCLES(SB_MAX_CYCLES)
) ems_seq_props_inst (
  .clk_i(clk_i),
  .rst_b_i(rst_b_i),
  .core_supply_ok_i(core_supply_ok_i),
  .hreadyout_o(hreadyout_o),
  .hresp_o(hresp_o),
  .pins_oe_allow_o(pins_oe_allow_o),
  .measuring_o(measuring_o),
  .cfg_o(cfg_o)
);
`default_nettype wire

// file: bench/ems_seq_tb.sv
// Purpose: Self-checking bench of the sequencer through its register bus.
// Assumes: Standby shortened to 4 cycles for code 0.
// Notes:   Expected samples are worked out from the filter equation.
`timescale 1ns/1ps
`default_nettype none
module ems_seq_tb;
  import ems_pkg::*;
  logic        clk_i;
  logic        rst_b_i;
  logic        core_supply_ok_i;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata_o;
  logic        hreadyout_o;
  logic        hresp_o;
  logic        pins_oe_allow_o;
  logic        measuring_o;
  ems_cfg_t    cfg_o;
  int          mismatches;
  int          samples_checked;
  ems_seq #(.SB_MIN_CYCLES(4), .SB_MAX_CYCLES(40)) ems_seq_inst (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .core_supply_ok_i(core_supply_ok_i),
    .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite),
    .hsize_i(hsize), .hwdata_i(hwdata), .hready_i(hreadyout_o),
    .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
    .pins_oe_allow_o(pins_oe_allow_o), .measuring_o(measuring_o),
    .cfg_o(cfg_o));
  ems_host ems_host_inst (
    .clk_i(clk_i), .hready_i(hreadyout_o), .hrdata_i(hrdata_o),
    .hsel_o(hsel), .haddr_o(haddr), .htrans_o(htrans), .hwrite_o(hwrite),
    .hsize_o(hsize), .hwdata_o(hwdata));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic test_done();
    mismatches += ems_host_inst.hangs;
    $display("Checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdchk(input string nm, input logic [7:0] a,
                       input logic [31:0] e);
    logic [31:0] d;
    ems_host_inst.rd(a, d);
    chk(nm, e, d);
  endtask : rdchk
  task automatic wait_lvl(input logic v);
    int n;
    n = 0;
    while (measuring_o !== v && n < 100) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 100) begin
      mismatches++;
      test_done();
    end
  endtask : wait_lvl
  task automatic forced(input logic [31:0] v);
    ems_host_inst.wr(REG_CTRL_MEAS, v);
    wait_lvl(1'b1);
    wait_lvl(1'b0);
    repeat (2) @(posedge clk_i);
  endtask : forced
  function automatic logic [31:0] meas(input logic [1:0] m,
                                       input logic [2:0] p, input logic [2:0] t);
    meas = {24'h0, t, p, m};
  endfunction : meas
  // Unfiltered output keeps 15 + code bits of the 20-bit sample.
  function automatic logic [31:0] res(input logic [19:0] s, input int c);
    res = {12'h0, s & (20'hfffff << (5 - c))};
  endfunction : res
  initial begin
    rst_b_i          = 1'b0;
    core_supply_ok_i = 1'b1;
    mismatches       = 0;
    samples_checked  = 0;
    repeat (2) @(posedge clk_i);
    rst_b_i <= 1'b1;
    @(posedge clk_i);
    chk("cfg_rst", 32'h0, {15'h0, cfg_o});
    chk("resp_okay", 32'h0, {31'h0, hresp_o});
    rdchk("pres_rst", REG_PRES, {12'h0, SKIP_VALUE});
    rdchk("hum_rst", REG_HUM, {16'h0, HUM_SKIP});
    rdchk("chip_id", REG_ID, CHIP_ID);
    rdchk("unmapped", 8'h3c, 32'h0);
    ems_host_inst.wr(REG_CONV_P, 32'h12345);
    ems_host_inst.wr(REG_CONV_T, 32'habcde);
    ems_host_inst.wr(REG_CONV_H, 32'h5a5a);
    ems_host_inst.wr(REG_CTRL_HUM, 32'h1);
    for (int c = 1; c <= 5; c++) begin
      forced(meas(2'(1 + c % 2), 3'(c), 3'(6 - c)));
      rdchk("pres_res", REG_PRES, res(20'h12345, c));
      rdchk("temp_res", REG_TEMP, res(20'habcde, 6 - c));
      chk("mode_back", 32'h0, {30'h0, cfg_o.mode});
    end
    rdchk("hum_res", REG_HUM, 32'h5a5a);
    ems_host_inst.wr(REG_CONFIG, 32'h4);
    forced(meas(2'h1, 3'h5, 3'h5));
    rdchk("p_init", REG_PRES, 32'h12345);
    ems_host_inst.wr(REG_CONV_P, 32'h12355);
    ems_host_inst.wr(REG_CONV_H, 32'h1234);
    forced(meas(2'h1, 3'h5, 3'h5));
    rdchk("p_filt2", REG_PRES, 32'h1234d);
    rdchk("h_raw", REG_HUM, 32'h1234);
    forced(meas(2'h1, 3'h0, 3'h5));
    rdchk("p_skip", REG_PRES, {12'h0, SKIP_VALUE});
    ems_host_inst.wr(REG_CONV_P, 32'h12365);
    forced(meas(2'h1, 3'h5, 3'h5));
    rdchk("p_resume", REG_PRES, 32'h12359);
    ems_host_inst.wr(REG_CONFIG, 32'h10);
    forced(meas(2'h1, 3'h5, 3'h5));
    rdchk("p_init16", REG_PRES, 32'h12365);
    ems_host_inst.wr(REG_CONV_P, 32'h12465);
    forced(meas(2'h1, 3'h5, 3'h5));
    rdchk("p_filt16", REG_PRES, 32'h12375);
    ems_host_inst.wr(REG_CTRL_MEAS, meas(2'h1, 3'h5, 3'h5));
    wait_lvl(1'b1);
    ems_host_inst.wr(REG_CTRL_MEAS, meas(2'h3, 3'h5, 3'h5));
    ems_host_inst.wr(REG_CTRL_MEAS, meas(2'h2, 3'h5, 3'h5));
    ems_host_inst.wr(REG_CTRL_HUM, 32'h4);
    @(posedge clk_i);
    chk("hum_hold", 32'h1, {29'h0, cfg_o.osrs_h});
    rdchk("status_pend", REG_STATUS, 32'h6);
    wait_lvl(1'b0);
    repeat (2) @(posedge clk_i);
    chk("mode_late", 32'h3, {30'h0, cfg_o.mode});
    ems_host_inst.wr(REG_CONV_H, 32'h0f0f);
    repeat (2) begin
      wait_lvl(1'b1);
      wait_lvl(1'b0);
    end
    rdchk("h_normal", REG_HUM, 32'h0f0f);
    wait_lvl(1'b1);
    ems_host_inst.wr(REG_RESET, {24'h0, RESET_KEY});
    repeat (3) @(posedge clk_i);
    chk("cfg_soft", 32'h0, {15'h0, cfg_o});
    rdchk("p_soft", REG_PRES, {12'h0, SKIP_VALUE});
    ems_host_inst.wr(REG_CTRL_HUM, 32'h3);
    @(posedge clk_i);
    chk("hum_set", 32'h3, {29'h0, cfg_o.osrs_h});
    core_supply_ok_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    chk("cfg_supply", 32'h0, {15'h0, cfg_o});
    chk("pins_off", 32'h0, {31'h0, pins_oe_allow_o});
    core_supply_ok_i <= 1'b1;
    @(posedge clk_i);
    chk("pins_on", 32'h1, {31'h0, pins_oe_allow_o});
    test_done();
  end
endmodule : ems_seq_tb
`default_nettype wire
